// >>> bench/rps_peer_model.sv
// Behavioural far-end peer switch on the overhead exchange byte
module rps_peer_model
  import rps_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Overhead link
  input wire logic oh_frame,
  input wire rps_oh_t tx_lane,
  input wire logic [3:0] req_chan,
  output rps_oh_t rx_lane [2]
);
  timeunit 1ns;
  timeprecision 1ps;
  rps_msg_t msg;
  logic [3:0] brg_r;
  logic ph_r;
  assign msg = tx_lane.sw;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brg_r <= 4'h0;
      ph_r <= 1'b0;
      rx_lane[0] <= '0;
      rx_lane[1] <= '0;
    end
    else if (oh_frame)
    begin
      if (msg.kind == RPS_MSG_REQ) brg_r <= msg.chan;
      ph_r <= ~ph_r;
      rx_lane[0] <= {1'b1, 8'h20, ph_r ? {RPS_MSG_BRG, 3'h0, brg_r}
                     : {RPS_MSG_REQ, 3'h0, req_chan}, 8'h5A};
      // Unused lane toggles so stale bytes never look valid
      rx_lane[1] <= {1'b0, ~rx_lane[0][23:0]};
    end
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the protection switch
module tb_top
  import rps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, unable, oh_frame;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0][7:0] wt_in, wl_in, wt_out, wl_out;
  logic [0:0][7:0] ot_in, pl_in, ot_out, pl_out;
  logic [3:0] sf, hber, lber, req_chan;
  logic [7:0] lew, phys_rx;
  logic [1:0] wsl, wsl_out;
  logic pl_ok, e;
  rps_oh_t sec_in [2], rad_in [2], sec_out [2], rad_out [2];
  int err_count, checked, n;

  rps_switch #(.SWITCH_CYC(64)) rps_switch_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wtrib_in(wt_in), .otrib_in(ot_in),
    .wtrib_out(wt_out), .otrib_out(ot_out), .wline_in(wl_in), .pline_in(pl_in),
    .wline_out(wl_out), .pline_out(pl_out), .sf(sf), .hber(hber), .lber(lber),
    .pline_ok(pl_ok), .protection_unable_flag(unable), .oh_frame(oh_frame),
    .section_overhead_port_in(sec_in), .radio_overhead_port_in(rad_in),
    .section_overhead_port_out(sec_out), .radio_overhead_port_out(rad_out),
    .phys_tx_in(8'hA5), .phys_rx_out(phys_rx), .local_ew(lew),
    .wayside_lost_in(wsl), .wayside_input_loss(wsl_out));
  rps_peer_model rps_peer_model_i (.pclk(pclk), .presetn(presetn), .oh_frame(oh_frame),
    .tx_lane(sec_out[0]), .req_chan(req_chan), .rx_lane(sec_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, x, s);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Overhead frame strobe every second cycle
  always @(posedge pclk) oh_frame <= presetn & ~oh_frame;
  initial
  begin
    #40000;
    err_count++;
    test_done;
  end
  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    sf = '0; hber = '0; lber = '0; pl_ok = 0; req_chan = '0;
    wt_in = 32'h44332211; wl_in = 32'hD4C3B2A1; pl_in = 8'hE7; ot_in = 8'h9C;
    lew = 8'h50; wsl = 2'b10; rad_in[0] = '0; rad_in[1] = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, RPS_SWSTAT_OFS, 0);
    chk("swstat", rd, 32'h0);
    apb(0, 12'h0FC, 0);
    chk("slverr", {31'h0, e}, 32'h1);
    repeat (4) @(posedge pclk);
    chk("wline", wl_out, wt_in);
    chk("wtrib", wt_out, wl_in);
    chk("otrib", ot_out, pl_in);
    chk("pline", pl_out, ot_in);
    chk("unable", {31'h0, unable}, 32'h0);
    apb(1, RPS_CTRL_OFS, 32'h1);
    sf[1] <= 1'b1; pl_ok <= 1'b1; req_chan <= 4'h2;
    for (n = 0; n < 300 && wt_out[1] !== pl_in[0]; n++) @(posedge pclk);
    chk("select", wt_out[1], pl_in[0]);
    chk("bridge", pl_out[0], wt_in[1]);
    chk("tx_phys", sec_out[0].phys, 8'hA5);
    chk("rx_phys", phys_rx, 8'h5A);
    apb(0, RPS_SWSTAT_OFS, 0);
    chk("sw_sf", rd & 32'h21, 32'h20);
    apb(0, RPS_PSTAT_OFS, 0);
    chk("pstat", rd & 32'hF000F, 32'h20002);
    apb(0, RPS_OHSTAT_OFS, 0);
    chk("ohstat", rd, 32'h02000070);
    sf[2] <= 1'b1; hber[3] <= 1'b1;
    for (n = 0; n < 300 && unable !== 1'b1; n++) @(posedge pclk);
    chk("unable2", {31'h0, unable}, 32'h1);
    chk("kept", wt_out[1], pl_in[0]);
    apb(0, RPS_CHSTAT_OFS, 0);
    chk("chstat", rd, 32'h4330);
    apb(1, RPS_LOCKP_OFS, 32'h1);
    apb(0, RPS_PSTAT_OFS, 0);
    chk("locked", rd & 32'hF, 32'h0);
    chk("unlocked", wt_out[1], wl_in[1]);
    sf <= '0; hber <= '0; req_chan <= 4'h0;
    apb(1, RPS_CTRL_OFS, 32'h3);
    repeat (40) @(posedge pclk);
    chk("one_plus", pl_out[0], wt_in[0]);
    test_done;
  end
endmodule

// >>> verilog/rps_chan_req.sv
// Per-channel ranking of commands and conditions into one request level
module rps_chan_req
  import rps_pkg::*;
(
  // Commands
  input wire logic lockout,
  input wire logic force_sw,
  input wire logic manual,
  input wire logic exercise,
  // Conditions
  input wire logic sf,
  input wire logic hber,
  input wire logic lber,
  input wire logic ew,
  // Result
  output logic [3:0] level
);

  always_comb
  begin
    if (lockout)
      level = RPS_LVL_LOCKOUT;
    else if (force_sw)
      level = RPS_LVL_FORCE;
    else if (sf)
      level = RPS_LVL_SF;
    else if (hber)
      level = RPS_LVL_HBER;
    else if (lber)
      level = RPS_LVL_LBER;
    else if (ew)
      level = RPS_LVL_EW;
    else if (manual)
      level = RPS_LVL_MANUAL;
    else if (exercise)
      level = RPS_LVL_EXER;
    else
      level = RPS_LVL_NONE;
  end

endmodule

// >>> verilog/rps_oh_access.sv
// Overhead access: exchange channel insert and extract, early warning merge
module rps_oh_access
  import rps_pkg::*;
#(
  parameter int WS = 2
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic oh_frame,
  input wire logic use_radio,
  input wire logic dup_en,
  input wire logic repeater,
  // Overhead bytes
  input wire rps_oh_t section_in [2],
  input wire rps_oh_t radio_in [2],
  output rps_oh_t section_out [2],
  output rps_oh_t radio_out [2],
  // Exchange channels
  input wire logic [7:0] tx_sw,
  input wire logic [7:0] tx_phys,
  output logic [7:0] rx_sw,
  output logic rx_sw_valid,
  output logic [7:0] rx_phys,
  // Early warning
  input wire logic [7:0] local_ew,
  output logic [7:0] ew_to_switch,
  // Wayside
  input wire logic [WS-1:0] wayside_lost_in,
  output logic [WS-1:0] wayside_input_loss
);

  rps_oh_t lane;
  rps_oh_t tx_lane;
  logic [7:0] ew_comb;

  ////////////////////////////////////////////////////////////////////////////
  // Lane choice, falling back to the duplicate lane
  always_comb
  begin
    if (use_radio)
      lane = (dup_en && !radio_in[0].ok) ? radio_in[1] : radio_in[0];
    else
      lane = (dup_en && !section_in[0].ok) ? section_in[1] : section_in[0];
    ew_comb = (lane.ok ? lane.ew : 8'h00) | local_ew;
    tx_lane.ok = 1'b1;
    tx_lane.ew = repeater ? ew_comb : 8'h00;
    tx_lane.sw = tx_sw;
    tx_lane.phys = tx_phys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extraction, once per frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_sw <= 8'h00;
      rx_sw_valid <= 1'b0;
      rx_phys <= 8'h00;
      ew_to_switch <= 8'h00;
    end
    else
    begin
      rx_sw_valid <= oh_frame && lane.ok;
      if (oh_frame)
      begin
        rx_sw <= lane.sw;
        rx_phys <= lane.phys;
        ew_to_switch <= repeater ? 8'h00 : ew_comb;
      end
    end
  end

  // Insertion, once per frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      section_out[0] <= '0;
      section_out[1] <= '0;
      radio_out[0] <= '0;
      radio_out[1] <= '0;
    end
    else if (oh_frame)
    begin
      section_out[0] <= use_radio ? '0 : tx_lane;
      section_out[1] <= (dup_en && !use_radio) ? tx_lane : '0;
      radio_out[0] <= use_radio ? tx_lane : '0;
      radio_out[1] <= (dup_en && use_radio) ? tx_lane : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wayside_input_loss <= '0;
    else
      wayside_input_loss <= wayside_lost_in;
  end

endmodule

// >>> verilog/rps_pkg.sv
// Shared constants, message layouts and state codes for the protection switch
package rps_pkg;

  // Register byte offsets
  localparam logic [11:0] RPS_CTRL_OFS = 12'h000;
  localparam logic [11:0] RPS_LOCKW_OFS = 12'h004;
  localparam logic [11:0] RPS_LOCKP_OFS = 12'h008;
  localparam logic [11:0] RPS_FORCE_OFS = 12'h00C;
  localparam logic [11:0] RPS_MANUAL_OFS = 12'h010;
  localparam logic [11:0] RPS_EXER_OFS = 12'h014;
  localparam logic [11:0] RPS_PRIO_OFS = 12'h018;
  localparam logic [11:0] RPS_SWSTAT_OFS = 12'h01C;
  localparam logic [11:0] RPS_CHSTAT_OFS = 12'h020;
  localparam logic [11:0] RPS_PSTAT_OFS = 12'h024;
  localparam logic [11:0] RPS_OHSTAT_OFS = 12'h028;

  // Control register fields
  localparam int RPS_CTRL_EN_BIT = 0;
  localparam int RPS_CTRL_1P1_BIT = 1;
  localparam int RPS_CTRL_RPT_BIT = 2;
  localparam int RPS_CTRL_RADIO_BIT = 3;
  localparam int RPS_CTRL_DUP_BIT = 4;
  localparam logic [4:0] RPS_CTRL_RST = 5'h00;

  // Request levels, lower is more urgent, zero is no request
  localparam logic [3:0] RPS_LVL_NONE = 4'h0;
  localparam logic [3:0] RPS_LVL_LOCKOUT = 4'h1;
  localparam logic [3:0] RPS_LVL_FORCE = 4'h2;
  localparam logic [3:0] RPS_LVL_SF = 4'h3;
  localparam logic [3:0] RPS_LVL_HBER = 4'h4;
  localparam logic [3:0] RPS_LVL_LBER = 4'h5;
  localparam logic [3:0] RPS_LVL_EW = 4'h6;
  localparam logic [3:0] RPS_LVL_MANUAL = 4'h7;
  localparam logic [3:0] RPS_LVL_EXER = 4'h8;

  // Switch completion time
  localparam longint unsigned RPS_CLK_HZ = 64'd250000000;
  localparam longint unsigned RPS_SWITCH_MS = 64'd10;
  localparam int RPS_SWITCH_CYC = int'(RPS_SWITCH_MS * RPS_CLK_HZ / 64'd1000);

  // Exchange byte on the switch exchange channel
  typedef struct packed {
    logic kind;
    logic [2:0] slot;
    logic [3:0] chan;
  } rps_msg_t;
  localparam logic RPS_MSG_REQ = 1'b0;
  localparam logic RPS_MSG_BRG = 1'b1;

  // One overhead lane per frame
  typedef struct packed {
    logic ok;
    logic [7:0] ew;
    logic [7:0] sw;
    logic [7:0] phys;
  } rps_oh_t;

  typedef enum logic [2:0] {
    RPS_SL_IDLE = 3'b001,
    RPS_SL_REQ = 3'b010,
    RPS_SL_SEL = 3'b100
  } rps_slot_st_t;

endpackage

// >>> verilog/rps_switch.sv
// Protection switch top: matrix, arbitration, peer signalling, APB registers
// How it works
// - m protection slots can each carry any one of the n working channels.
// - a switch not completed within 10 ms is flagged.
// - coordination uses only the dedicated exchange byte, never multiplex-section APS bytes.
// - both ends run identical logic watching all n working channels.
// - slots go to channels ranked by command or condition level, then assigned priority.
// - requests and bridge status travel to the peer on the exchange channel.
// - in 1+1 mode channel one is always bridged, no signalling needed.
// - protection-unable flag rises when any requesting channel stays unprotected.
// - switch status register shows every active alarm and command.
// - per-channel status registers show the active request for each channel.
// - the matrix passes data unchanged.
// - ports split into line side and tributary side, each in and out.
// - overhead access inserts and extracts the exchange channels in overhead bytes.
// - overhead access may duplicate the exchange channels on a second lane.
// - early warnings from overhead merge with local receiver warnings.
// - merged warnings go onward in repeaters, to the switch in terminals.
// - wayside input loss is reported per channel.
// - each working tributary feeds its working line and the distributor.
// - a peer request bridges that channel from the distributor to a protection line.
// - select protection only after the peer confirms the bridge (outside 1+1 mode) and content is good.
// - when slots run out, lowest ranked requests are denied or preempted.
//
// Local design decisions: the placing of the registers and register access over APB.
module rps_switch
  import rps_pkg::*;
#(
  parameter int N = 4,
  parameter int M = 1,
  parameter int W = 8,
  parameter int WS = 2,
  parameter int SWITCH_CYC = RPS_SWITCH_CYC
)(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tributary side
  input wire logic [N-1:0][W-1:0] wtrib_in,
  input wire logic [M-1:0][W-1:0] otrib_in,
  output logic [N-1:0][W-1:0] wtrib_out,
  output logic [M-1:0][W-1:0] otrib_out,
  // Line side
  input wire logic [N-1:0][W-1:0] wline_in,
  input wire logic [M-1:0][W-1:0] pline_in,
  output logic [N-1:0][W-1:0] wline_out,
  output logic [M-1:0][W-1:0] pline_out,
  // Switch status port
  input wire logic [N-1:0] sf,
  input wire logic [N-1:0] hber,
  input wire logic [N-1:0] lber,
  input wire logic [M-1:0] pline_ok,
  output logic protection_unable_flag,
  // Overhead ports
  input wire logic oh_frame,
  input wire rps_oh_t section_overhead_port_in [2],
  input wire rps_oh_t radio_overhead_port_in [2],
  output rps_oh_t section_overhead_port_out [2],
  output rps_oh_t radio_overhead_port_out [2],
  // Radio physical interface exchange and status
  input wire logic [7:0] phys_tx_in,
  output logic [7:0] phys_rx_out,
  input wire logic [7:0] local_ew,
  input wire logic [WS-1:0] wayside_lost_in,
  output logic [WS-1:0] wayside_input_loss
);

  logic [4:0] ctrl_r;
  logic [N-1:0] lockw_r, force_r, manual_r, exer_r;
  logic [M-1:0] lockp_r;
  logic [2*N-1:0] prio_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  rps_slot_st_t st_r [M];
  logic [3:0] chan_r [M];
  logic [31:0] tmr_r [M];
  logic [3:0] far_req_r [M];
  logic [3:0] far_brg_r [M];
  logic [3:0] tx_ptr_r;
  logic unable_r;
  logic [N-1:0][W-1:0] wline_r, wtrib_r;
  logic [M-1:0][W-1:0] pline_r, otrib_r;
  logic [7:0] ew_sw, rx_sw;
  logic rx_sw_valid;
  logic [3:0] lvl [N];
  logic [5:0] key [N];
  logic [N-1:0] req_ok, served, ew_ch;
  logic [3:0] best_c, brg [M];
  logic [5:0] best_k, worst_k;
  logic free_found, any_served, preempt;
  int free_s, worst_s;
  logic [M-1:0] release_s;
  rps_msg_t tx_msg, rx_msg;
  logic en, one_p1;
  logic [31:0] rd_nxt;
  logic map_ok;

  assign en = ctrl_r[RPS_CTRL_EN_BIT];
  assign one_p1 = ctrl_r[RPS_CTRL_1P1_BIT];
  assign ew_ch = ew_sw[N-1:0];
  assign rx_msg = rx_sw;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel levels
  for (genvar i = 0; i < N; i++)
  begin : g_ch
    rps_chan_req u_req (
      .lockout(lockw_r[i]),
      .force_sw(force_r[i]),
      .manual(manual_r[i]),
      .exercise(exer_r[i]),
      .sf(sf[i]),
      .hber(hber[i]),
      .lber(lber[i]),
      .ew(ew_ch[i]),
      .level(lvl[i])
    );
  end

  rps_oh_access #(.WS(WS)) u_oh (
    .pclk(pclk),
    .presetn(presetn),
    .oh_frame(oh_frame),
    .use_radio(ctrl_r[RPS_CTRL_RADIO_BIT]),
    .dup_en(ctrl_r[RPS_CTRL_DUP_BIT]),
    .repeater(ctrl_r[RPS_CTRL_RPT_BIT]),
    .section_in(section_overhead_port_in),
    .radio_in(radio_overhead_port_in),
    .section_out(section_overhead_port_out),
    .radio_out(radio_overhead_port_out),
    .tx_sw(tx_msg),
    .tx_phys(phys_tx_in),
    .rx_sw(rx_sw),
    .rx_sw_valid(rx_sw_valid),
    .rx_phys(phys_rx_out),
    .local_ew(local_ew),
    .ew_to_switch(ew_sw),
    .wayside_lost_in(wayside_lost_in),
    .wayside_input_loss(wayside_input_loss)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration: at most one slot assignment per cycle, release decided for every slot
  always_comb
  begin
    best_c = 4'h0;
    best_k = 6'h3F;
    worst_k = 6'h00;
    worst_s = 0;
    free_s = 0;
    free_found = 1'b0;
    any_served = 1'b0;
    served = '0;
    for (int i = 0; i < N; i++)
    begin
      req_ok[i] = (lvl[i] != RPS_LVL_NONE) && (lvl[i] != RPS_LVL_LOCKOUT);
      key[i] = {lvl[i], prio_r[2*i +: 2]};
    end
    for (int s = 0; s < M; s++)
      for (int i = 0; i < N; i++)
        if (chan_r[s] == 4'(i + 1))
        begin
          served[i] = 1'b1;
          any_served = 1'b1;
          if (key[i] >= worst_k)
          begin
            worst_k = key[i];
            worst_s = s;
          end
        end
    for (int i = 0; i < N; i++)
      if (req_ok[i] && !served[i] && key[i] < best_k)
      begin
        best_k = key[i];
        best_c = 4'(i + 1);
      end
    for (int s = M - 1; s >= 0; s--)
      if (chan_r[s] == 4'h0 && !lockp_r[s])
      begin
        free_s = s;
        free_found = 1'b1;
      end
    preempt = en && best_c != 4'h0 && !free_found && any_served && best_k < worst_k;
    for (int s = 0; s < M; s++)
    begin
      release_s[s] = !en || lockp_r[s] || (preempt && s == worst_s);
      for (int i = 0; i < N; i++)
        if (chan_r[s] == 4'(i + 1) && !req_ok[i])
          release_s[s] = 1'b1;
      brg[s] = (one_p1 && s == 0) ? 4'h1 : far_req_r[s];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot state machines
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int s = 0; s < M; s++)
      begin
        st_r[s] <= RPS_SL_IDLE;
        chan_r[s] <= 4'h0;
        tmr_r[s] <= 32'h0;
      end
    end
    else
    begin
      for (int s = 0; s < M; s++)
      begin
        case (st_r[s])
          RPS_SL_IDLE:
          begin
            tmr_r[s] <= 32'h0;
            if (en && best_c != 4'h0 && free_found && free_s == s && !release_s[s])
            begin
              chan_r[s] <= best_c;
              st_r[s] <= RPS_SL_REQ;
            end
          end
          RPS_SL_REQ:
          begin
            if (tmr_r[s] < SWITCH_CYC)
              tmr_r[s] <= tmr_r[s] + 32'h1;
            if (release_s[s])
            begin
              chan_r[s] <= 4'h0;
              st_r[s] <= RPS_SL_IDLE;
            end
            else if ((one_p1 || far_brg_r[s] == chan_r[s]) && pline_ok[s])
              st_r[s] <= RPS_SL_SEL;
          end
          RPS_SL_SEL:
          begin
            tmr_r[s] <= 32'h0;
            if (release_s[s])
            begin
              chan_r[s] <= 4'h0;
              st_r[s] <= RPS_SL_IDLE;
            end
            else if (!pline_ok[s])
              st_r[s] <= RPS_SL_REQ;
          end
          default:
          begin
            chan_r[s] <= 4'h0;
            st_r[s] <= RPS_SL_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peer exchange: request and bridge state per slot, rotating each frame
  always_comb
  begin
    tx_msg.kind = tx_ptr_r[0];
    tx_msg.slot = tx_ptr_r[3:1];
    tx_msg.chan = 4'h0;
    for (int s = 0; s < M; s++)
      if (tx_ptr_r[3:1] == 3'(s))
        tx_msg.chan = tx_ptr_r[0] ? brg[s] : chan_r[s];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_ptr_r <= 4'h0;
      for (int s = 0; s < M; s++)
      begin
        far_req_r[s] <= 4'h0;
        far_brg_r[s] <= 4'h0;
      end
    end
    else
    begin
      if (oh_frame)
        tx_ptr_r <= (tx_ptr_r == 4'(2 * M - 1)) ? 4'h0 : tx_ptr_r + 4'h1;
      for (int s = 0; s < M; s++)
        if (!en || one_p1)
        begin
          far_req_r[s] <= 4'h0;
          far_brg_r[s] <= 4'h0;
        end
        else if (rx_sw_valid && rx_msg.slot == 3'(s) && rx_msg.chan <= 4'(N))
        begin
          if (rx_msg.kind == RPS_MSG_REQ)
            far_req_r[s] <= rx_msg.chan;
          else
            far_brg_r[s] <= rx_msg.chan;
        end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Connection matrix
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wline_r <= '0;
      wtrib_r <= '0;
      pline_r <= '0;
      otrib_r <= '0;
    end
    else
    begin
      wline_r <= wtrib_in;
      otrib_r <= pline_in;
      for (int i = 0; i < N; i++)
      begin
        wtrib_r[i] <= wline_in[i];
        for (int s = 0; s < M; s++)
          if (st_r[s] == RPS_SL_SEL && chan_r[s] == 4'(i + 1))
            wtrib_r[i] <= pline_in[s];
      end
      for (int s = 0; s < M; s++)
      begin
        pline_r[s] <= otrib_in[s];
        for (int i = 0; i < N; i++)
          if (brg[s] == 4'(i + 1))
            pline_r[s] <= wtrib_in[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unable_r <= 1'b0;
    else
    begin
      unable_r <= 1'b0;
      for (int i = 0; i < N; i++)
        if (en && req_ok[i] && !served[i])
          unable_r <= 1'b1;
      for (int s = 0; s < M; s++)
        if (st_r[s] == RPS_SL_REQ && tmr_r[s] >= SWITCH_CYC)
          unable_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  always_comb
  begin
    map_ok = 1'b1;
    rd_nxt = 32'h0;
    case (paddr)
      RPS_CTRL_OFS: rd_nxt = 32'(ctrl_r);
      RPS_LOCKW_OFS: rd_nxt = 32'(lockw_r);
      RPS_LOCKP_OFS: rd_nxt = 32'(lockp_r);
      RPS_FORCE_OFS: rd_nxt = 32'(force_r);
      RPS_MANUAL_OFS: rd_nxt = 32'(manual_r);
      RPS_EXER_OFS: rd_nxt = 32'(exer_r);
      RPS_PRIO_OFS: rd_nxt = 32'(prio_r);
      RPS_SWSTAT_OFS:
        rd_nxt = {16'h0, 8'(served), |ew_ch, |(hber | lber), |sf, |exer_r, |manual_r,
          |force_r, |(lockw_r) | |(lockp_r), unable_r};
      RPS_CHSTAT_OFS:
        for (int i = 0; i < N; i++)
          rd_nxt[4*i +: 4] = lvl[i];
      RPS_PSTAT_OFS:
        for (int s = 0; s < M; s++)
        begin
          rd_nxt[4*s +: 4] = chan_r[s];
          rd_nxt[16 + 4*s +: 4] = far_req_r[s];
        end
      RPS_OHSTAT_OFS: rd_nxt = {8'(wayside_input_loss), 16'h0, ew_sw};
      default: map_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end
    else
    begin
      pready_r <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !map_ok;
      prdata_r <= (psel && penable && !pready_r && !pwrite) ? rd_nxt : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= RPS_CTRL_RST;
      lockw_r <= '0;
      lockp_r <= '0;
      force_r <= '0;
      manual_r <= '0;
      exer_r <= '0;
      prio_r <= '0;
    end
    else if (psel && penable && pready_r && pwrite)
    begin
      case (paddr)
        RPS_CTRL_OFS: ctrl_r <= pwdata[4:0];
        RPS_LOCKW_OFS: lockw_r <= pwdata[N-1:0];
        RPS_LOCKP_OFS: lockp_r <= pwdata[M-1:0];
        RPS_FORCE_OFS: force_r <= pwdata[N-1:0];
        RPS_MANUAL_OFS: manual_r <= pwdata[N-1:0];
        RPS_EXER_OFS: exer_r <= pwdata[N-1:0];
        RPS_PRIO_OFS: prio_r <= pwdata[2*N-1:0];
        default: ;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign protection_unable_flag = unable_r;
  assign wline_out = wline_r;
  assign wtrib_out = wtrib_r;
  assign pline_out = pline_r;
  assign otrib_out = otrib_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_sel_after_bridge;
    @(posedge pclk) disable iff (!presetn)
    (st_r[0] == RPS_SL_REQ && $past(st_r[0]) == RPS_SL_REQ && !one_p1) ##1 st_r[0] == RPS_SL_SEL
      |-> $past(far_brg_r[0]) == $past(chan_r[0]) && $past(pline_ok[0]);
  endproperty
  a_sel_after_bridge: assert property (p_sel_after_bridge) else $error("select before bridge");
  property p_wline_copy;
    @(posedge pclk) disable iff (!presetn) $past(presetn) |-> wline_out == $past(wtrib_in);
  endproperty
  a_wline_copy: assert property (p_wline_copy) else $error("working line not copied");
  property p_disabled_idle;
    @(posedge pclk) disable iff (!presetn) !en |=> chan_r[0] == 4'h0 && st_r[0] == RPS_SL_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("slot busy while off");
  property p_timeout_flag;
    @(posedge pclk) disable iff (!presetn)
    (st_r[0] == RPS_SL_REQ && tmr_r[0] >= SWITCH_CYC) |=> protection_unable_flag;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag) else $error("timeout not flagged");
  property p_unserved_flag;
    @(posedge pclk) disable iff (!presetn)
    (en && |(req_ok & ~served)) |=> protection_unable_flag;
  endproperty
  a_unserved_flag: assert property (p_unserved_flag) else $error("denied not flagged");
  property p_occ_pass;
    @(posedge pclk) disable iff (!presetn)
    (presetn && !one_p1 && far_req_r[0] == 4'h0) |=> pline_out[0] == $past(otrib_in[0]);
  endproperty
  a_occ_pass: assert property (p_occ_pass) else $error("occasional not on line");
  property p_one_plus_one;
    @(posedge pclk) disable iff (!presetn) one_p1 |=> pline_out[0] == $past(wtrib_in[0]);
  endproperty
  a_one_plus_one: assert property (p_one_plus_one) else $error("1+1 bridge missing");
  property p_otrib_pass;
    @(posedge pclk) disable iff (!presetn) $past(presetn) |-> otrib_out == $past(pline_in);
  endproperty
  a_otrib_pass: assert property (p_otrib_pass) else $error("matrix altered data");
  property p_lockout_release;
    @(posedge pclk) disable iff (!presetn) lockp_r[0] |=> chan_r[0] == 4'h0;
  endproperty
  a_lockout_release: assert property (p_lockout_release) else $error("locked slot used");

endmodule
